//--- include/rnm_defs.svh
// constants for the requester node map word bank
`ifndef RNM_DEFS_SVH
`define RNM_DEFS_SVH

// ==========================================================================
// geometry and addressing
`define RNM_ENTRIES        128
`define RNM_IDX_W          7
`define RNM_BASE_ADDR      12'h000
`define RNM_WORD_STRIDE    8
`define RNM_LO_OFS         3'h0
`define RNM_HI_OFS         3'h4

// ==========================================================================
// field positions in the 64-bit word
`define RNM_UP_USE_BIT     63
`define RNM_UP_AGG_BIT     62
`define RNM_UP_KIND_HI     57
`define RNM_UP_KIND_LO     54
`define RNM_UP_GRP_HI      51
`define RNM_UP_GRP_LO      49
`define RNM_UP_FAR_BIT     48
`define RNM_UP_ID_HI       42
`define RNM_UP_ID_LO       32
`define RNM_LO_USE_BIT     31
`define RNM_LO_AGG_BIT     30
`define RNM_LO_KIND_HI     25
`define RNM_LO_KIND_LO     22
`define RNM_LO_GRP_HI      19
`define RNM_LO_GRP_LO      17
`define RNM_LO_FAR_BIT     16
`define RNM_LO_ID_HI       10
`define RNM_LO_ID_LO       0

// ==========================================================================
// writable mask of one 32-bit half; reserved bits are zero
`define RNM_HALF_RW_MASK   32'hC3CF07FF
`define RNM_SLOT_RESET     32'h00000000

// ==========================================================================
// requester kind codes and highest aggregation group
`define RNM_KIND_B         4'hA
`define RNM_KIND_C         4'hB
`define RNM_KIND_D         4'hC
`define RNM_GROUP_MAX      3'h4

`endif

//--- include/rnm_pkg.sv
// types for the requester node map word bank
package rnm_pkg;

    typedef struct packed {
        logic        in_use;
        logic        aggregation_on;
        logic [3:0]  requester_kind;
        logic [2:0]  aggregation_group;
        logic        far_flag;
        logic [10:0] mesh_id;
    } rnm_slot_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
        logic [3:0]  pstrb;
        logic [2:0]  pprot;
    } rnm_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } rnm_apb_rsp_t;

endpackage

//--- core/rnm_half.sv
// one 32-bit half of a map word: slot storage with reserved bits masked
`timescale 1ns/1ps
`include "rnm_defs.svh"

module rnm_half
(
    // clock and reset
    input  wire logic        clock_in,
    input  wire logic        rst_in,
    // write port
    input  wire logic        wr_en_in,
    input  wire logic [31:0] wr_data_in,
    input  wire logic [3:0]  wr_strb_in,
    // stored half, reserved bits zero
    output logic      [31:0] half_out
);
    logic [31:0] half_ff;
    logic [31:0] byte_mask;
    logic [31:0] nxt_half;

    assign byte_mask = {{8{wr_strb_in[3]}}, {8{wr_strb_in[2]}},
                        {8{wr_strb_in[1]}}, {8{wr_strb_in[0]}}};
    // reserved bits never stored, so they read zero [RULE_08] [RULE_10]
    assign nxt_half = (half_ff & ~byte_mask)
                    | (wr_data_in & byte_mask & `RNM_HALF_RW_MASK);

    always_ff @(posedge clock_in)
    begin
        if (rst_in)
            half_ff <= `RNM_SLOT_RESET;
        else if (wr_en_in)
            half_ff <= nxt_half;
    end

    assign half_out = half_ff;
endmodule

//--- core/rnm_bank.sv
// requester node map word bank: 128 secure-only 64-bit words over apb
//
// Contract
// [RULE_01] only secure accesses read or write words
// [RULE_02] in-use flag at bits 63 and 31
// [RULE_03] aggregation enable at bits 62 and 30
// [RULE_04] four-bit requester kind, reset zero
// [RULE_05] three-bit aggregation group, reset zero
// [RULE_06] far flag at bits 48 and 16
// [RULE_07] eleven-bit mesh id, reset zero
// [RULE_08] reserved bits are read-only
// [RULE_09] one word per index, 128 entries
// [RULE_10] reserved bits read zero, writes ignored
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ps
`include "rnm_defs.svh"

module rnm_bank
#(
    parameter int ENTRIES = `RNM_ENTRIES
)
(
    // clock and reset
    input  wire logic                  clock_in,
    input  wire logic                  rst_in,
    // apb slave
    input  wire rnm_pkg::rnm_apb_req_t apb_req_in,
    output rnm_pkg::rnm_apb_rsp_t      apb_rsp_out,
    // decoded view of the selected entry, for the node's lookup logic
    input  wire logic [`RNM_IDX_W-1:0] view_idx_in,
    output rnm_pkg::rnm_slot_t         upper_slot_out,
    output rnm_pkg::rnm_slot_t         lower_slot_out
);
    import rnm_pkg::*;

    // ======================================================================
    // address decode
    logic [`RNM_IDX_W-1:0] acc_idx;
    logic [2:0]            acc_ofs;
    logic                  in_range;
    logic                  aligned;
    logic                  secure;
    logic                  access;
    logic                  hit;
    logic                  wr_hit;
    logic                  ack_ff;

    assign acc_idx  = apb_req_in.paddr[`RNM_IDX_W+2:3];
    assign acc_ofs  = apb_req_in.paddr[2:0];
    assign in_range = (apb_req_in.paddr[11:`RNM_IDX_W+3] == 2'h0)
                   && (32'(acc_idx) < 32'(ENTRIES));
    assign aligned  = (acc_ofs == `RNM_LO_OFS) || (acc_ofs == `RNM_HI_OFS);
    // pprot[1] low marks a secure access
    assign secure   = ~apb_req_in.pprot[1];
    assign access   = apb_req_in.psel && apb_req_in.penable;
    assign hit      = in_range && aligned && secure; // [RULE_01]
    // store only at the pready edge, not in the wait state
    assign wr_hit   = access && apb_req_in.pwrite && hit && ack_ff;

    // ======================================================================
    // storage: two halves per entry
    logic [31:0] lo_half [ENTRIES];
    logic [31:0] hi_half [ENTRIES];

    genvar g;
    generate
        for (g = 0; g < ENTRIES; g++)
        begin : g_entry // [RULE_09]
            logic sel;
            assign sel = wr_hit && (32'(acc_idx) == g);
            // reset zero covers every field of both slots
            rnm_half u_lo
            (
                .clock_in   (clock_in),
                .rst_in     (rst_in),
                .wr_en_in   (sel && (acc_ofs == `RNM_LO_OFS)),
                .wr_data_in (apb_req_in.pwdata),
                .wr_strb_in (apb_req_in.pstrb),
                .half_out   (lo_half[g])
            ); // [RULE_02] [RULE_03] [RULE_04] [RULE_05]
            rnm_half u_hi
            (
                .clock_in   (clock_in),
                .rst_in     (rst_in),
                .wr_en_in   (sel && (acc_ofs == `RNM_HI_OFS)),
                .wr_data_in (apb_req_in.pwdata),
                .wr_strb_in (apb_req_in.pstrb),
                .half_out   (hi_half[g])
            ); // [RULE_06] [RULE_07]
        end
    endgenerate

    // ======================================================================
    // read path: registered data, one wait state
    logic        err_ff;
    logic [31:0] rdata_ff;
    logic [31:0] rd_word;
    logic        first;

    assign rd_word = !hit ? 32'h00000000
                   : (acc_ofs == `RNM_HI_OFS) ? hi_half[acc_idx]
                   : lo_half[acc_idx]; // [RULE_01] [RULE_10]
    assign first   = access && !ack_ff;

    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            ack_ff   <= 1'b0;
            err_ff   <= 1'b0;
            rdata_ff <= 32'h00000000;
        end
        else
        begin
            ack_ff   <= first;
            err_ff   <= first && !hit;
            rdata_ff <= first ? rd_word : 32'h00000000;
        end
    end

    assign apb_rsp_out.pready  = ack_ff;
    assign apb_rsp_out.pslverr = ack_ff && err_ff;
    assign apb_rsp_out.prdata  = rdata_ff;

    // ======================================================================
    // slot view
    logic [63:0] view_word;
    assign view_word = {hi_half[view_idx_in], lo_half[view_idx_in]};

    assign upper_slot_out.in_use            = view_word[`RNM_UP_USE_BIT];
    assign upper_slot_out.aggregation_on    = view_word[`RNM_UP_AGG_BIT];
    assign upper_slot_out.requester_kind    =
        view_word[`RNM_UP_KIND_HI:`RNM_UP_KIND_LO];
    assign upper_slot_out.aggregation_group =
        view_word[`RNM_UP_GRP_HI:`RNM_UP_GRP_LO];
    assign upper_slot_out.far_flag          = view_word[`RNM_UP_FAR_BIT];
    assign upper_slot_out.mesh_id           =
        view_word[`RNM_UP_ID_HI:`RNM_UP_ID_LO];
    assign lower_slot_out.in_use            = view_word[`RNM_LO_USE_BIT];
    assign lower_slot_out.aggregation_on    = view_word[`RNM_LO_AGG_BIT];
    assign lower_slot_out.requester_kind    =
        view_word[`RNM_LO_KIND_HI:`RNM_LO_KIND_LO];
    assign lower_slot_out.aggregation_group =
        view_word[`RNM_LO_GRP_HI:`RNM_LO_GRP_LO];
    assign lower_slot_out.far_flag          = view_word[`RNM_LO_FAR_BIT];
    assign lower_slot_out.mesh_id           =
        view_word[`RNM_LO_ID_HI:`RNM_LO_ID_LO];
endmodule

//--- sim/rnm_bank_chk.sv
// port assertions for the requester node map bank
`timescale 1ns/1ps
`include "rnm_defs.svh"

module rnm_bank_chk
#(
    parameter int ENTRIES = `RNM_ENTRIES
)
(
    input  wire logic                  clock_in,
    input  wire logic                  rst_in,
    input  wire rnm_pkg::rnm_apb_req_t apb_req_in,
    input  wire rnm_pkg::rnm_apb_rsp_t apb_rsp_out,
    input  wire logic [`RNM_IDX_W-1:0] view_idx_in,
    input  wire rnm_pkg::rnm_slot_t    upper_slot_out,
    input  wire rnm_pkg::rnm_slot_t    lower_slot_out
);
    import rnm_pkg::*;
    // ==========================================================
    // decode
    wire        rdy = apb_rsp_out.pready;
    wire [31:0] d   = apb_req_in.pwdata;
    wire [20:0] wf  = {d[31:30], d[25:22], d[19:16], d[10:0]};
    wire        ok  = apb_req_in.psel && apb_req_in.penable
        && !apb_req_in.pprot[1] && apb_req_in.paddr[11:10] == 2'h0
        && apb_req_in.paddr[1:0] == 2'h0;
    wire        wok = ok && apb_req_in.pwrite;
    // full-strobe hits on the viewed entry only: partial ones merge
    wire        hit = wok && rdy && apb_req_in.pstrb == 4'hF
        && apb_req_in.paddr[9:3] == view_idx_in;
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);
    // ==========================================================
    // assertions
    AST_RDY: assert property (
        apb_req_in.psel && !apb_req_in.penable |=> !rdy ##1 rdy)
        else $error("pready not after one wait state");
    AST_NSEC: assert property (
        rdy && apb_req_in.pprot[1] |->
        apb_rsp_out.pslverr && apb_rsp_out.prdata == 32'h0)
        else $error("non-secure access not refused");
    AST_SEC: assert property (
        rdy && ok |-> !apb_rsp_out.pslverr)
        else $error("legal access refused");
    AST_RSV: assert property (
        rdy |-> (apb_rsp_out.prdata & ~`RNM_HALF_RW_MASK) == 32'h0)
        else $error("reserved bit reads one");
    AST_HOLD: assert property (
        !(wok && rdy) |=> !$stable(view_idx_in)
        || ($stable(upper_slot_out) && $stable(lower_slot_out)))
        else $error("slot changed without a legal write");
    AST_WRLO: assert property (
        hit && !apb_req_in.paddr[2] |=> !$stable(view_idx_in)
        || lower_slot_out == $past(wf))
        else $error("lower slot not written");
    AST_WRUP: assert property (
        hit && apb_req_in.paddr[2] |=> !$stable(view_idx_in)
        || upper_slot_out == $past(wf))
        else $error("upper slot not written");
    AST_RST: assert property (disable iff (1'b0)
        rst_in |=> upper_slot_out == '0 && lower_slot_out == '0 && !rdy)
        else $error("slots not cleared by reset");
endmodule

bind rnm_bank rnm_bank_chk #(.ENTRIES(ENTRIES)) rnm_bank_chk_i (
    .clock_in(clock_in), .rst_in(rst_in), .apb_req_in(apb_req_in),
    .apb_rsp_out(apb_rsp_out), .view_idx_in(view_idx_in),
    .upper_slot_out(upper_slot_out), .lower_slot_out(lower_slot_out));

//--- sim/test_rnm_bank.sv
// self-checking bench for the requester node map bank
`timescale 1ns/1ps
`include "rnm_defs.svh"

module test_rnm_bank;
    import rnm_pkg::*;
    logic         clock_in = 1'b0;
    logic         rst_in   = 1'b1;
    rnm_apb_req_t q        = '0;
    rnm_apb_rsp_t r;
    logic [6:0]   vi       = 7'h00;
    rnm_slot_t    up;
    rnm_slot_t    lo;
    logic [31:0]  m [0:255];
    int           failures    = 0;
    int           comparisons = 0;
    int           cyc         = 0;

    rnm_bank rnm_bank_i (.clock_in(clock_in), .rst_in(rst_in),
        .apb_req_in(q), .apb_rsp_out(r), .view_idx_in(vi),
        .upper_slot_out(up), .lower_slot_out(lo));

    // ==========================================================
    // clock, timeout, helpers
    initial
    begin
        forever #12.5 clock_in = ~clock_in;
    end
    always @(posedge clock_in)
    begin
        cyc <= cyc + 1;
        if (cyc == 4000)
        begin
            failures++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s, e);
        comparisons++;
        if (s !== e)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    function automatic logic [20:0] fx(input logic [31:0] w);
        return {w[31:30], w[25:22], w[19:16], w[10:0]};
    endfunction
    // model: index is entry*2 plus half, as paddr[9:2]
    task automatic xfer(input logic w, input logic [11:0] a,
        input logic [31:0] d, input logic [3:0] s, input logic [2:0] p);
        logic [31:0] mk;
        logic        er;
        mk = '0;
        er = p[1] || a[11:10] != 2'h0 || a[1:0] != 2'h0;
        for (int i = 0; i < 4; i++)
            if (s[i]) mk[8*i+:8] = 8'hFF;
        q <= '{1'b1, 1'b0, w, a, d, s, p};
        @(posedge clock_in);
        q.penable <= 1'b1;
        vi <= a[9:3];
        do @(posedge clock_in); while (r.pready !== 1'b1);
        chk("pslverr", r.pslverr, er);
        if (!w)
            chk("prdata", r.prdata, er ? 32'h0 : m[a[9:2]]);
        else if (!er)
            m[a[9:2]] = (m[a[9:2]] & ~mk | d & mk) & `RNM_HALF_RW_MASK;
    endtask
    task automatic sweep();
        for (int i = 0; i < 128; i++)
        begin
            @(posedge clock_in);
            vi <= 7'(i);
            #1;
            chk("upper", up, fx(m[2*i+1]));
            chk("lower", lo, fx(m[2*i]));
        end
        // return on an edge so a request can follow right after it
        @(posedge clock_in);
    endtask
    task automatic rst_seq();
        @(posedge clock_in);
        rst_in <= 1'b1;
        q <= '0;
        foreach (m[k]) m[k] = '0;
        repeat (2) @(posedge clock_in);
        rst_in <= 1'b0;
        @(posedge clock_in);
    endtask

    // ==========================================================
    // main sequence
    initial
    begin
        logic [11:0] a;
        void'($urandom(3));
        rst_seq();
        sweep();
        // reserved bits written as ones, all kinds and groups
        for (int i = 0; i < 15; i++)
        begin
            a = {2'h0, 7'(i), 3'(i % 2 * 4)};
            xfer(1'b1, a, {2'h3, 4'hF, `RNM_KIND_B + 4'(i % 3), 2'h3,
                3'(i % 5), 1'b1, 5'h1F, 11'(i * 137)}, 4'hF, 3'h0);
            xfer(1'b0, a, 32'h0, 4'hF, 3'h0);
        end
        for (int i = 0; i < 400; i++)
        begin
            a = 12'($urandom);
            if ($urandom % 4 != 0) a[11:10] = 2'h0;
            if ($urandom % 4 != 0) a[1:0] = 2'h0;
            if ($urandom % 2 != 0) a[9:6] = 4'h0;
            xfer(1'($urandom), a, $urandom, 4'($urandom), 3'($urandom));
        end
        q <= '0;
        sweep();
        rst_seq();
        sweep();
        tally_and_finish();
    end
endmodule
